// *** core/pdic_map.vh ***
/*
 Register offsets, field positions, reset values and timing constants of the
 power detector release and crossing filter block.
 Assumes inclusion by bare name from the design file.
*/
`ifndef PDIC_MAP_VH
`define PDIC_MAP_VH
`define PDIC_ADDR_W          9
`define PDIC_OFS_REL_LO      9'h00b
`define PDIC_OFS_REL_HI      9'h00c
`define PDIC_OFS_SEL         9'h00d
`define PDIC_OFS_TC          9'h00e
`define PDIC_OFS_UP_LO       9'h00f
`define PDIC_OFS_UP_HI       9'h010
`define PDIC_OFS_LW_LO       9'h011
`define PDIC_OFS_LW_HI       9'h012
`define PDIC_OFS_IRQ_STAT    9'h030
`define PDIC_OFS_IRQ_MASK    9'h031
`define PDIC_OFS_STATUS      9'h032
`define PDIC_RST_BYTE        8'h00
`define PDIC_RST_SEL         1'b0
`define PDIC_RST_TC          4'h0
`define PDIC_RST_MASK        5'h00
`define PDIC_SEL_BIT         0
`define PDIC_TC_MSB          3
`define PDIC_DIV             8
`define PDIC_DIV_W           3
`define PDIC_TICK_LAST       3'h7
`define PDIC_IRQ_PK_SET      0
`define PDIC_IRQ_PK_CLR      1
`define PDIC_IRQ_IIR_SET     2
`define PDIC_IRQ_IIR_CLR     3
`define PDIC_IRQ_PERIOD      4
`endif

// *** core/pdic_core.v ***
/*
 Power detector release delay, crossing filter input select, crossing period
 and filter 0 thresholds, with a byte register port and a status interrupt.
 Assumes comparator outputs and filter output are synchronous to core_clk,
 and that core_clk runs at the sample rate divided down by the caller.
 The filter release count arrives on a port because its register sits in
 the neighbouring block. Software is expected to keep the peak release
 count at zero while crossing detection is in use; nothing here enforces
 that.
*/
// The implementer's own choice: the plain strobed port.
//Overview of operation
//RQ1: Peak flag sets when block peak exceeds the high-high or low-high limit.
//RQ2: Peak flag clears after peak stays below lower limit for release count.
//RQ3: Release count is 16 bits over two bytes, in eighth-rate clock cycles.
//RQ4: Software writes a zero release count while crossing detection is used.
//RQ5: Select clear feeds the filter only from high-high and high-low outputs.
//RQ6: Select set merges high and low comparators into a -1, 0, +1 input.
//RQ7: Exponent N in bits 3..0 sets crossing period to 2**N eighth-rate cycles.
//RQ8: Filter thresholds are 16-bit signed 2.14 values, 4000 hex means all.
//RQ9: Filter flag sets above upper limit, clears after release below lower.
//RQ10: Software writes zeros to unused upper bits of select and exponent.
`timescale 1ns/100ps
`include "pdic_map.vh"
module pdic_core (
	input  wire        core_clk,
	input  wire        resetn,
	input  wire [8:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire        cmp_hh,
	input  wire        cmp_hl,
	input  wire        cmp_lh,
	input  wire        cmp_ll,
	input  wire        iir_out_valid,
	input  wire [15:0] iir_out,
	input  wire [15:0] iir_release_count,
	output reg         peak_flag,
	output reg         iir_flag,
	output reg  [1:0]  iir_in,
	output reg         iir_in_valid,
	output reg         period_tick,
	output reg         irq
);
	reg [7:0]  rel_lo;
	reg [7:0]  rel_hi;
	reg        sel;
	reg [3:0]  tc;
	reg [7:0]  up_lo;
	reg [7:0]  up_hi;
	reg [7:0]  lw_lo;
	reg [7:0]  lw_hi;
	reg [4:0]  irq_stat;
	reg [4:0]  irq_mask;
	reg [2:0]  div_cnt;
	reg [15:0] pk_cnt;
	reg [15:0] iir_cnt;
	reg [15:0] per_cnt;
	reg [7:0]  next_rdata;

	// One-cycle event strobes, one per status bit.
	reg        ev_pk_set;
	reg        ev_pk_clr;
	reg        ev_iir_set;
	reg        ev_iir_clr;
	reg        ev_per;

	// Sixteen-bit values are taken live from their byte pairs.
	wire [4:0]  ev;
	wire        tick;
	wire [15:0] rel_count;
	wire [15:0] per_len;
	wire signed [15:0] up_lim;
	wire signed [15:0] lw_lim;
	wire signed [15:0] iir_s;
	wire        pk_above;
	wire        pk_below;
	wire        rd_stat;

	// Counting advances once per eight core cycles. [RQ3]
	assign tick = (div_cnt == `PDIC_TICK_LAST);
	assign rel_count = {rel_hi, rel_lo}; // [RQ3]
	assign per_len = 16'h0001 << tc; // [RQ7]
	// Thresholds are compared as signed 2.14 values.
	assign up_lim = {up_hi, up_lo}; // [RQ8]
	assign lw_lim = {lw_hi, lw_lo}; // [RQ8]
	assign iir_s = iir_out;
	assign pk_above = cmp_hh | cmp_lh; // [RQ1]
	assign pk_below = ~cmp_hl & ~cmp_ll; // [RQ2]
	assign rd_stat = reg_rd && (reg_addr == `PDIC_OFS_IRQ_STAT);

	// Status bit positions come from the map header.
	assign ev[`PDIC_IRQ_PK_SET]  = ev_pk_set;
	assign ev[`PDIC_IRQ_PK_CLR]  = ev_pk_clr;
	assign ev[`PDIC_IRQ_IIR_SET] = ev_iir_set;
	assign ev[`PDIC_IRQ_IIR_CLR] = ev_iir_clr;
	assign ev[`PDIC_IRQ_PERIOD]  = ev_per;

	// Free-running divider; its phase is not tied to register writes, so a
	// new setting takes effect at the next tick, not at a fresh phase.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt <= 3'd0;
		end else begin
			div_cnt <= div_cnt + 3'd1;
		end
	end

	// Register writes; unused upper bits are dropped on write, so they
	// always read back as zero whatever software wrote.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rel_lo   <= `PDIC_RST_BYTE;
			rel_hi   <= `PDIC_RST_BYTE;
			sel      <= `PDIC_RST_SEL;
			tc       <= `PDIC_RST_TC;
			up_lo    <= `PDIC_RST_BYTE;
			up_hi    <= `PDIC_RST_BYTE;
			lw_lo    <= `PDIC_RST_BYTE;
			lw_hi    <= `PDIC_RST_BYTE;
			irq_mask <= `PDIC_RST_MASK;
		end else if (reg_wr) begin
			if (reg_addr == `PDIC_OFS_REL_LO) begin
				rel_lo <= reg_wdata;
			end else if (reg_addr == `PDIC_OFS_REL_HI) begin
				rel_hi <= reg_wdata;
			end else if (reg_addr == `PDIC_OFS_SEL) begin
				sel <= reg_wdata[`PDIC_SEL_BIT];
			end else if (reg_addr == `PDIC_OFS_TC) begin
				tc <= reg_wdata[`PDIC_TC_MSB:0];
			end else if (reg_addr == `PDIC_OFS_UP_LO) begin
				up_lo <= reg_wdata;
			end else if (reg_addr == `PDIC_OFS_UP_HI) begin
				up_hi <= reg_wdata;
			end else if (reg_addr == `PDIC_OFS_LW_LO) begin
				lw_lo <= reg_wdata;
			end else if (reg_addr == `PDIC_OFS_LW_HI) begin
				lw_hi <= reg_wdata;
			end else if (reg_addr == `PDIC_OFS_IRQ_MASK) begin
				irq_mask <= reg_wdata[4:0];
			end
		end
	end

	// Peak flag. A zero release count clears on the first quiet tick, which
	// is what crossing detection expects. A comparator that is neither above
	// nor quiet restarts the count, so a release always measures one
	// unbroken quiet stretch. Release R therefore takes R + 1 ticks, which
	// trades one tick of latency for a simple compare.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			peak_flag <= 1'b0;
			pk_cnt    <= 16'h0000;
			ev_pk_set <= 1'b0;
			ev_pk_clr <= 1'b0;
		end else begin
			ev_pk_set <= 1'b0;
			ev_pk_clr <= 1'b0;
			if (pk_above) begin
				ev_pk_set <= ~peak_flag;
				peak_flag <= 1'b1; // [RQ1]
				pk_cnt    <= 16'h0000;
			end else if (!pk_below) begin
				pk_cnt <= 16'h0000; // [RQ2]
			end else if (peak_flag && tick) begin
				if (pk_cnt >= rel_count) begin
					peak_flag <= 1'b0; // [RQ2]
					ev_pk_clr <= 1'b1;
					pk_cnt    <= 16'h0000;
				end else begin
					pk_cnt <= pk_cnt + 16'h0001;
				end
			end
		end
	end

	// Filter input: one-bit or three-level coding in two bits.
	// When high and low comparators fire together the positive level wins,
	// since the high pair marks the larger excursion.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			iir_in       <= 2'b00;
			iir_in_valid <= 1'b0;
		end else begin
			iir_in_valid <= tick;
			if (!sel) begin
				iir_in <= {1'b0, cmp_hh | cmp_hl}; // [RQ5]
			end else if (cmp_hh | cmp_hl) begin
				iir_in <= 2'b01; // [RQ6]
			end else if (cmp_lh | cmp_ll) begin
				iir_in <= 2'b11; // [RQ6]
			end else begin
				iir_in <= 2'b00; // [RQ6]
			end
		end
	end

	// Crossing period counter in eighth-rate cycles.
	// A shorter exponent written mid-period, once the count has reached the new
	// length, ends the period at the next tick instead of letting the counter run past it.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			per_cnt     <= 16'h0000;
			period_tick <= 1'b0;
			ev_per      <= 1'b0;
		end else begin
			period_tick <= 1'b0;
			ev_per      <= 1'b0;
			if (tick) begin
				if (per_cnt >= per_len - 16'h0001) begin
					per_cnt     <= 16'h0000; // [RQ7]
					period_tick <= 1'b1;
					ev_per      <= 1'b1;
				end else begin
					per_cnt <= per_cnt + 16'h0001;
				end
			end
		end
	end

	// Filter flag with signed threshold compares.
	// A negative filter output counts as below any lower limit of zero or more.
	// Cycles without valid neither set the flag nor restart the count.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			iir_flag   <= 1'b0;
			iir_cnt    <= 16'h0000;
			ev_iir_set <= 1'b0;
			ev_iir_clr <= 1'b0;
		end else begin
			ev_iir_set <= 1'b0;
			ev_iir_clr <= 1'b0;
			if (iir_out_valid && (iir_s > up_lim)) begin
				ev_iir_set <= ~iir_flag;
				iir_flag <= 1'b1; // [RQ9]
				iir_cnt  <= 16'h0000;
			end else if (iir_out_valid && !(iir_s < lw_lim)) begin
				iir_cnt <= 16'h0000; // [RQ9]
			end else if (iir_flag && tick) begin
				if (iir_cnt >= iir_release_count) begin
					iir_flag <= 1'b0; // [RQ9]
					ev_iir_clr <= 1'b1;
					iir_cnt  <= 16'h0000;
				end else begin
					iir_cnt <= iir_cnt + 16'h0001;
				end
			end
		end
	end

	// Sticky events; a new event in the read cycle survives the clear.
	// The read hands back the bits set before the clear, and the interrupt
	// is a flop fed from the same next status, so it changes with the status.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat <= 5'h00;
			irq      <= 1'b0;
		end else begin
			irq_stat <= (rd_stat ? 5'h00 : irq_stat) | ev;
			irq      <= |(((rd_stat ? 5'h00 : irq_stat) | ev) & irq_mask);
		end
	end

	// Unmapped addresses read as zero.
	always @* begin
		next_rdata = 8'h00;
		if (reg_addr == `PDIC_OFS_REL_LO) begin
			next_rdata = rel_lo;
		end else if (reg_addr == `PDIC_OFS_REL_HI) begin
			next_rdata = rel_hi;
		end else if (reg_addr == `PDIC_OFS_SEL) begin
			next_rdata = {7'h00, sel};
		end else if (reg_addr == `PDIC_OFS_TC) begin
			next_rdata = {4'h0, tc};
		end else if (reg_addr == `PDIC_OFS_UP_LO) begin
			next_rdata = up_lo;
		end else if (reg_addr == `PDIC_OFS_UP_HI) begin
			next_rdata = up_hi;
		end else if (reg_addr == `PDIC_OFS_LW_LO) begin
			next_rdata = lw_lo;
		end else if (reg_addr == `PDIC_OFS_LW_HI) begin
			next_rdata = lw_hi;
		end else if (reg_addr == `PDIC_OFS_IRQ_STAT) begin
			next_rdata = {3'h0, irq_stat};
		end else if (reg_addr == `PDIC_OFS_IRQ_MASK) begin
			next_rdata = {3'h0, irq_mask};
		end else if (reg_addr == `PDIC_OFS_STATUS) begin
			next_rdata = {6'h00, iir_flag, peak_flag};
		end
	end

	// Read data stands only in the cycle after the strobe and is zero
	// otherwise, so several slaves can share one OR-ed return path.
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? next_rdata : 8'h00;
		end
	end
endmodule

// *** test/pdic_chk.sv ***
/*
 Port checker for pdic_core.
 Bound from the testbench; watches the core ports only.
*/
`timescale 1ns/100ps
module pdic_chk (
	input wire       core_clk,
	input wire       resetn,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       cmp_hh,
	input wire       cmp_hl,
	input wire       cmp_lh,
	input wire       cmp_ll,
	input wire       iir_out_valid,
	input wire       peak_flag,
	input wire       iir_flag,
	input wire [1:0] iir_in,
	input wire       iir_in_valid,
	input wire       period_tick
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	pk_set_a: assert property ((cmp_hh | cmp_lh) |=> peak_flag)
		else $error("peak flag missed a set");
	pk_hold_a: assert property (peak_flag & (cmp_hl | cmp_ll) |=> peak_flag)
		else $error("peak flag cleared while not quiet");
	pk_fall_a: assert property ($fell(peak_flag) |-> iir_in_valid)
		else $error("peak flag cleared off a tick");
	div_space_a: assert property (iir_in_valid |=> !iir_in_valid [*7] ##1 iir_in_valid)
		else $error("tick spacing is not eight");
	per_space_a: assert property (period_tick |=> !period_tick [*7])
		else $error("period shorter than one tick");
	in_code_a: assert property (iir_in_valid |-> iir_in != 2'h2)
		else $error("illegal filter input code");
	iir_rise_a: assert property ($rose(iir_flag) |-> $past(iir_out_valid))
		else $error("filter flag set without valid");
	iir_fall_a: assert property ($fell(iir_flag) |-> iir_in_valid)
		else $error("filter flag cleared off a tick");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	cover property ($fell(peak_flag));
	cover property ($fell(iir_flag));
	cover property (period_tick ##8 period_tick);
endmodule

// *** test/testbench.sv ***
/*
 Self-checking bench for pdic_core over its byte register port.
 Assumes the core and its map header are compiled before this file.
*/
`timescale 1ns/100ps
module testbench;
	logic        core_clk = '0;
	logic        resetn = '0;
	logic [8:0]  reg_addr = '0;
	logic [7:0]  reg_wdata = '0;
	logic        reg_wr = '0;
	logic        reg_rd = '0;
	logic        cmp_hh = '0;
	logic        cmp_hl = '0;
	logic        cmp_lh = '0;
	logic        cmp_ll = '0;
	logic        iir_out_valid = '0;
	logic [15:0] iir_out = '0;
	logic [15:0] iir_release_count = '0;
	wire  [7:0]  reg_rdata;
	wire  [1:0]  iir_in;
	wire         peak_flag, iir_flag, iir_in_valid, period_tick, irq;
	int          fails = 0;
	int          checked = 0;
	int          k;
	int          n;
	logic [7:0]  v;
	pdic_core u_pdic_core (
		.core_clk          (core_clk),
		.resetn            (resetn),
		.reg_addr          (reg_addr),
		.reg_wdata         (reg_wdata),
		.reg_wr            (reg_wr),
		.reg_rd            (reg_rd),
		.reg_rdata         (reg_rdata),
		.cmp_hh            (cmp_hh),
		.cmp_hl            (cmp_hl),
		.cmp_lh            (cmp_lh),
		.cmp_ll            (cmp_ll),
		.iir_out_valid     (iir_out_valid),
		.iir_out           (iir_out),
		.iir_release_count (iir_release_count),
		.peak_flag         (peak_flag),
		.iir_flag          (iir_flag),
		.iir_in            (iir_in),
		.iir_in_valid      (iir_in_valid),
		.period_tick       (period_tick),
		.irq               (irq)
	);
	always #2 core_clk = ~core_clk;
	task automatic close_out;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic lim(input int i);
		if (i >= 10000) begin
			fails++;
			close_out;
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	task automatic rc(input logic [8:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	// Counts tick-aligned valid pulses so checks land on fresh samples.
	task automatic ticks(input int m);
		int i;
		int c;
		c = 0;
		for (i = 0; i < 10000 && c < m; i++) begin
			@(posedge core_clk);
			#1 c += iir_in_valid;
		end
		lim(i);
	endtask
	task automatic pwait(output int c);
		for (c = 1; c < 10000; c++) begin
			@(posedge core_clk);
			#1;
			if (period_tick === 1'h1)
				break;
		end
		lim(c);
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		resetn <= 1'h1;
		for (k = 0; k < 8; k++)
			rc(9'h00b + k, 8'h00);
		// Select and exponent get zeros in their unused bits.
		for (k = 0; k < 8; k++) begin
			v = k == 2 ? 8'h01 : k == 3 ? 8'h0f : 8'hff;
			wr(9'h00b + k, v);
			rc(9'h00b + k, v);
		end
		wr(9'h020, 8'hff);
		rc(9'h020, 8'h00);
		wr(9'h031, 8'hff);
		rc(9'h031, 8'h1f);
		wr(9'h00d, 8'h00);
		wr(9'h00e, 8'h00);
		wr(9'h00b, 8'h02);
		wr(9'h00c, 8'h01);
		wr(9'h031, 8'h01);
		@(posedge core_clk);
		cmp_hh <= 1'h1;
		cmp_hl <= 1'h1;
		repeat (3) @(posedge core_clk);
		#1 chk(peak_flag, 1'h1);
		chk(irq, 1'h1);
		rc(9'h032, 8'h01);
		@(posedge core_clk);
		cmp_hh <= 1'h0;
		cmp_hl <= 1'h0;
		// A release of 0x0102 must take that many ticks plus one.
		n = 0;
		for (k = 0; k < 10000 && peak_flag; k++) begin
			@(posedge core_clk);
			#1 n += iir_in_valid;
		end
		lim(k);
		chk(n, 16'h0103);
		rd(9'h030, v);
		chk(v & 8'h03, 8'h03);
		@(posedge core_clk);
		#1 chk(irq, 1'h0);
		for (k = 0; k < 4; k++) begin
			wr(9'h00d, {7'h00, k[1]});
			cmp_hh <= ~k[0];
			cmp_lh <= ~k[0];
			cmp_ll <= k[0];
			ticks(2);
			chk(iir_in, k[0] ? {k[1], k[1]} : 2'h1);
		end
		@(posedge core_clk);
		cmp_hh <= 1'h0;
		cmp_lh <= 1'h0;
		cmp_ll <= 1'h0;
		ticks(2);
		chk(iir_in, 2'h0);
		wr(9'h00b, 8'h00);
		wr(9'h00c, 8'h00);
		for (k = 0; k < 9; k += 4) begin
			wr(9'h00e, k[7:0]);
			pwait(n);
			pwait(n);
			pwait(n);
			chk(n, 16'h0008 << k);
		end
		wr(9'h00f, 8'h00);
		wr(9'h010, 8'h08);
		wr(9'h011, 8'h00);
		wr(9'h012, 8'h04);
		iir_out <= 16'h0800;
		iir_out_valid <= 1'h1;
		ticks(2);
		chk(iir_flag, 1'h0);
		@(posedge core_clk);
		iir_out <= 16'h4000;
		ticks(2);
		chk(iir_flag, 1'h1);
		@(posedge core_clk);
		iir_out <= 16'h0600;
		iir_release_count <= 16'h0003;
		ticks(2);
		chk(iir_flag, 1'h1);
		// A negative output is below the limit; release 3 takes four ticks.
		@(posedge core_clk);
		iir_out <= 16'hf000;
		n = 0;
		for (k = 0; k < 10000 && iir_flag === 1'h1; k++) begin
			@(posedge core_clk);
			#1 n += iir_in_valid;
		end
		lim(k);
		chk(n, 16'h0004);
		chk(iir_flag, 1'h0);
		close_out;
	end
endmodule
bind pdic_core pdic_chk u_pdic_chk (
	.core_clk      (core_clk),
	.resetn        (resetn),
	.reg_rd        (reg_rd),
	.reg_rdata     (reg_rdata),
	.cmp_hh        (cmp_hh),
	.cmp_hl        (cmp_hl),
	.cmp_lh        (cmp_lh),
	.cmp_ll        (cmp_ll),
	.iir_out_valid (iir_out_valid),
	.peak_flag     (peak_flag),
	.iir_flag      (iir_flag),
	.iir_in        (iir_in),
	.iir_in_valid  (iir_in_valid),
	.period_tick   (period_tick)
);
